//--- core/tim_pkg.sv
/*
  Shared constants of the tuner two-wire bus master: register offsets, field
  positions, reset values, bus timing and the engine state codes.
  Assumes a link clock of 80 ns period drives the bus engine.
*/
package tim_pkg;

  // Register offsets, as seen on the register port.
  localparam logic [7:0] ADDR_SLAVE = 8'h55;
  localparam logic [7:0] ADDR_DATA_FIRST = 8'h56;
  localparam logic [7:0] ADDR_DATA_LAST = 8'h5d;
  localparam logic [7:0] ADDR_CTRL = 8'h5e;
  localparam logic [7:0] ADDR_IRQ_RAW = 8'hf9;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hfb;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hfd;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'hff;

  // Field positions.
  localparam int SLAVE_DIR_BIT = 0;
  localparam int CTRL_RATE_BIT = 0;
  localparam int CTRL_BUSY_BIT = 1;
  localparam int CTRL_START_BIT = 2;
  localparam int CTRL_SUBADDR_BIT = 3;
  localparam int CTRL_CNT_LSB = 5;
  localparam int CTRL_CNT_MSB = 7;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;

  // Reset values.
  localparam logic [7:0] SLAVE_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [2:0] CNT_RST = 3'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // Bus timing: one bit is four quarter periods of the bus clock.
  localparam int LINK_CLK_PERIOD_NS = 80;
  localparam int STD_QUARTER_NS = 2500;
  localparam int FAST_QUARTER_NS = 625;
  localparam int STD_QUARTER_CYC = (STD_QUARTER_NS + LINK_CLK_PERIOD_NS - 1) / LINK_CLK_PERIOD_NS;
  localparam int FAST_QUARTER_CYC = (FAST_QUARTER_NS + LINK_CLK_PERIOD_NS - 1) / LINK_CLK_PERIOD_NS;
  localparam int QCNT_W = 6;

  // Bus engine states.
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_START = 5'b00010,
    ST_TXB   = 5'b00100,
    ST_RXB   = 5'b01000,
    ST_STOP  = 5'b10000
  } tim_state_t;

endpackage

//--- core/tim_tuner_i2c_master.sv
/*
  Tuner two-wire bus master: register file on sys_clk, bus engine on linkClk.
  Assumes the register port is driven synchronously to sys_clk, open-drain
  pull-ups outside, and sys_rst held long enough to cover a few linkClk edges.
*/
`timescale 1ns/1ns
module tim_tuner_i2c_master (
  // System side.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Interrupt request.
  output logic interruptRequestOut,
  // Link clock of the bus engine.
  input wire logic linkClk,
  // Tuner bus clock pin, open drain.
  input wire logic tunerBusClockIn,
  output logic tunerBusClockOut,
  output logic tunerBusClockOeN,
  // Tuner bus data pin, open drain.
  input wire logic tunerBusDataIn,
  output logic tunerBusDataOut,
  output logic tunerBusDataOeN
);

  // System domain registers.
  logic [7:0] slave_q;
  logic [7:0] data_q [8];
  logic [2:0] cnt_q;
  logic rate_q;
  logic subEn_q;
  logic busy_q;
  logic startTgl_q;
  logic [1:0] raw_q;
  logic [1:0] mask_q;
  logic irq_q;
  logic [7:0] rdData_q;
  logic [2:0] finSync_q;
  logic finLvl_q;

  // Link domain registers.
  logic [1:0] linkRstSync_q;
  logic [2:0] stSync_q;
  logic stLvl_q;
  logic [2:0] sclSync_q;
  logic [2:0] sdaSync_q;
  logic sclLvl_q;
  logic sdaLvl_q;
  tim_pkg::tim_state_t state_q;
  logic [1:0] phase_q;
  logic [3:0] bit_q;
  logic [8:0] shift_q;
  logic [7:0] rxSh_q;
  logic [2:0] idx_q;
  logic isAddr_q;
  logic rdPhase2_q;
  logic ackBad_q;
  logic err_q;
  logic [tim_pkg::QCNT_W-1:0] qCnt_q;
  logic [7:0] rxBuf_q [8];
  logic finTgl_q;
  logic finErr_q;
  logic sclOeN_q;
  logic sdaOeN_q;
  logic sclOut_q;
  logic sdaOut_q;

  // Register decode on the system side.
  wire [7:0] dataOff = regAddr - tim_pkg::ADDR_DATA_FIRST;
  wire [2:0] dataIdx = dataOff[2:0];
  wire selData = (regAddr >= tim_pkg::ADDR_DATA_FIRST) && (regAddr <= tim_pkg::ADDR_DATA_LAST);
  wire wrSlave = regWrEn && (regAddr == tim_pkg::ADDR_SLAVE) && !busy_q;
  wire wrData = regWrEn && selData && !busy_q;
  wire wrCtrl = regWrEn && (regAddr == tim_pkg::ADDR_CTRL) && !busy_q;
  wire wrMask = regWrEn && (regAddr == tim_pkg::ADDR_IRQ_MASK);
  wire wrClear = regWrEn && (regAddr == tim_pkg::ADDR_IRQ_CLEAR);
  wire startReq = wrCtrl && regWrData[tim_pkg::CTRL_START_BIT];
  wire rdMode = slave_q[tim_pkg::SLAVE_DIR_BIT];
  wire [2:0] lastIdx = cnt_q - 3'h1;

  // Finish event: the toggle is taken once the second and third stages agree.
  wire finAgree = finSync_q[1] == finSync_q[2];
  wire finEvent = finAgree && (finSync_q[2] != finLvl_q);
  wire finOk = finEvent && !finErr_q;
  wire [1:0] rawSet = {finEvent && finErr_q, finOk};
  wire [1:0] rawClr = wrClear ? regWrData[1:0] : 2'h0;
  wire [1:0] rawNext = (raw_q & ~rawClr) | rawSet;
  wire [1:0] statusView = raw_q & mask_q;
  wire [7:0] ctrlView = {cnt_q, 1'b0, subEn_q, 1'b0, busy_q, rate_q};

  // Read multiplexer; unmapped offsets read as zero.
  wire [7:0] rdMux = (regAddr == tim_pkg::ADDR_SLAVE) ? slave_q :
                     selData ? data_q[dataIdx] :
                     (regAddr == tim_pkg::ADDR_CTRL) ? ctrlView :
                     (regAddr == tim_pkg::ADDR_IRQ_RAW) ? {6'h00, raw_q} :
                     (regAddr == tim_pkg::ADDR_IRQ_STATUS) ? {6'h00, statusView} :
                     (regAddr == tim_pkg::ADDR_IRQ_MASK) ? {6'h00, mask_q} : 8'h00;

  // Staging registers; all but the mask are frozen while a transaction runs, so the engine may read them directly.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      slave_q <= tim_pkg::SLAVE_RST;
      cnt_q <= tim_pkg::CNT_RST;
      rate_q <= 1'b0;
      subEn_q <= 1'b0;
      mask_q <= tim_pkg::IRQ_RST;
    end else begin
      if (wrSlave) begin
        slave_q <= regWrData;
      end
      if (wrCtrl) begin
        cnt_q <= regWrData[tim_pkg::CTRL_CNT_MSB:tim_pkg::CTRL_CNT_LSB];
        rate_q <= regWrData[tim_pkg::CTRL_RATE_BIT];
        subEn_q <= regWrData[tim_pkg::CTRL_SUBADDR_BIT];
      end
      if (wrMask) begin
        mask_q <= regWrData[1:0];
      end
    end
  end

  // Data registers: host writes, and received bytes land here after a good read.
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (sys_rst) begin
        data_q[i] <= tim_pkg::DATA_RST;
      end else if (wrData && (dataIdx == 3'(i))) begin
        data_q[i] <= regWrData;
      end else if (finOk && rdMode && (3'(i) <= lastIdx)) begin
        data_q[i] <= rxBuf_q[i];
      end
    end
  end

  // Start handshake and outcome flags; a set in the clear cycle wins.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      startTgl_q <= 1'b0;
      finSync_q <= 3'h0;
      finLvl_q <= 1'b0;
      raw_q <= tim_pkg::IRQ_RST;
      irq_q <= 1'b0;
      rdData_q <= 8'h00;
    end else begin
      finSync_q <= {finSync_q[1:0], finTgl_q};
      if (finAgree) begin
        finLvl_q <= finSync_q[2];
      end
      if (startReq) begin
        startTgl_q <= ~startTgl_q;
        busy_q <= 1'b1;
      end else if (finEvent) begin
        busy_q <= 1'b0;
      end
      raw_q <= rawNext;
      irq_q <= |(raw_q & mask_q);
      if (regRdEn) begin
        rdData_q <= rdMux;
      end
    end
  end

  // Link domain reset and input conditioning.
  wire linkRst = linkRstSync_q[1];
  wire stAgree = stSync_q[1] == stSync_q[2];
  wire startEvent = stAgree && (stSync_q[2] != stLvl_q);

  always_ff @(posedge linkClk) begin
    linkRstSync_q <= {linkRstSync_q[0], sys_rst};
    stSync_q <= {stSync_q[1:0], startTgl_q};
    sclSync_q <= {sclSync_q[1:0], tunerBusClockIn};
    sdaSync_q <= {sdaSync_q[1:0], tunerBusDataIn};
    if (sclSync_q[1] == sclSync_q[2]) begin
      sclLvl_q <= sclSync_q[2];
    end
    if (sdaSync_q[1] == sdaSync_q[2]) begin
      sdaLvl_q <= sdaSync_q[2];
    end
  end

  // Quarter-bit timer; holding while the tuner stretches the clock low.
  wire [tim_pkg::QCNT_W-1:0] qLoad = rate_q ? tim_pkg::QCNT_W'(tim_pkg::FAST_QUARTER_CYC - 1) :
                                              tim_pkg::QCNT_W'(tim_pkg::STD_QUARTER_CYC - 1);
  wire stretch = (phase_q == 2'd2) && sclOeN_q && !sclLvl_q;
  wire busActive = state_q != tim_pkg::ST_IDLE;
  wire tick = busActive && (qCnt_q == '0) && !stretch;
  wire lastByte = idx_q == lastIdx;
  wire [2:0] idxNext = idx_q + 3'h1;
  wire [7:0] addrByte = {slave_q[7:1], rdPhase2_q};
  wire byteEnd = (phase_q == 2'd3) && (bit_q == 4'd8);

  always_ff @(posedge linkClk) begin
    if (linkRst || !busActive || (qCnt_q == '0 && !stretch)) begin
      qCnt_q <= qLoad;
    end else if (!stretch) begin
      qCnt_q <= qCnt_q - 1'b1;
    end
  end

  // Bus engine; a lone master, so lost arbitration is never checked.
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      stLvl_q <= 1'b0;
      state_q <= tim_pkg::ST_IDLE;
      phase_q <= 2'd0;
      bit_q <= 4'd0;
      shift_q <= 9'h1ff;
      rxSh_q <= 8'h00;
      idx_q <= 3'h0;
      isAddr_q <= 1'b0;
      rdPhase2_q <= 1'b0;
      ackBad_q <= 1'b0;
      err_q <= 1'b0;
      finTgl_q <= 1'b0;
      finErr_q <= 1'b0;
      sclOeN_q <= 1'b1;
      sdaOeN_q <= 1'b1;
      sclOut_q <= 1'b0;
      sdaOut_q <= 1'b0;
    end else begin
      if (stAgree) begin
        stLvl_q <= stSync_q[2];
      end
      if (startEvent && !busActive) begin
        state_q <= tim_pkg::ST_START;
        phase_q <= 2'd0;
        idx_q <= 3'h0;
        err_q <= 1'b0;
        rdPhase2_q <= 1'b0;
      end else if (tick) begin
        phase_q <= phase_q + 2'd1;
        unique case (state_q)
          tim_pkg::ST_START: begin
            if (phase_q == 2'd0) begin
              sclOeN_q <= 1'b1;
              sdaOeN_q <= 1'b1;
            end else if (phase_q == 2'd2) begin
              sdaOeN_q <= 1'b0;
            end else if (phase_q == 2'd3) begin
              sclOeN_q <= 1'b0;
              state_q <= tim_pkg::ST_TXB;
              shift_q <= {addrByte, 1'b1};
              bit_q <= 4'd0;
              isAddr_q <= 1'b1;
            end
          end
          tim_pkg::ST_TXB: begin
            if (phase_q == 2'd0) begin
              sdaOeN_q <= shift_q[8];
            end else if (phase_q == 2'd1) begin
              sclOeN_q <= 1'b1;
            end else if (phase_q == 2'd2) begin
              ackBad_q <= (bit_q == 4'd8) && sdaLvl_q;
            end else begin
              sclOeN_q <= 1'b0;
              shift_q <= {shift_q[7:0], 1'b1};
              bit_q <= bit_q + 4'd1;
              if (byteEnd) begin
                bit_q <= 4'd0;
                if (ackBad_q) begin
                  err_q <= 1'b1;
                  state_q <= tim_pkg::ST_STOP;
                end else if (isAddr_q) begin
                  isAddr_q <= 1'b0;
                  if (rdPhase2_q) begin
                    state_q <= tim_pkg::ST_RXB;
                  end else if (!rdMode || subEn_q) begin
                    shift_q <= {data_q[0], 1'b1};
                  end else begin
                    state_q <= tim_pkg::ST_STOP;
                  end
                end else if (rdMode || lastByte) begin
                  state_q <= tim_pkg::ST_STOP;
                end else begin
                  idx_q <= idxNext;
                  shift_q <= {data_q[idxNext], 1'b1};
                end
              end
            end
          end
          tim_pkg::ST_RXB: begin
            if (phase_q == 2'd0) begin
              sdaOeN_q <= (bit_q == 4'd8) ? lastByte : 1'b1;
            end else if (phase_q == 2'd1) begin
              sclOeN_q <= 1'b1;
            end else if (phase_q == 2'd2) begin
              if (bit_q != 4'd8) begin
                rxSh_q <= {rxSh_q[6:0], sdaLvl_q};
              end
            end else begin
              sclOeN_q <= 1'b0;
              bit_q <= bit_q + 4'd1;
              if (byteEnd) begin
                bit_q <= 4'd0;
                rxBuf_q[idx_q] <= rxSh_q;
                if (lastByte) begin
                  state_q <= tim_pkg::ST_STOP;
                end else begin
                  idx_q <= idxNext;
                end
              end
            end
          end
          tim_pkg::ST_STOP: begin
            if (phase_q == 2'd0) begin
              sdaOeN_q <= 1'b0;
            end else if (phase_q == 2'd1) begin
              sclOeN_q <= 1'b1;
            end else if (phase_q == 2'd2) begin
              sdaOeN_q <= 1'b1;
            end else if (rdMode && !rdPhase2_q && !err_q) begin
              rdPhase2_q <= 1'b1;
              idx_q <= 3'h0;
              state_q <= tim_pkg::ST_START;
            end else begin
              finErr_q <= err_q;
              finTgl_q <= ~finTgl_q;
              state_q <= tim_pkg::ST_IDLE;
            end
          end
          default: begin
            state_q <= tim_pkg::ST_IDLE;
          end
        endcase
      end
      sclOut_q <= 1'b0;
      sdaOut_q <= 1'b0;
    end
  end

  // Outputs come straight from flip-flops; pins only ever pull low.
  assign regRdData = rdData_q;
  assign interruptRequestOut = irq_q;
  assign tunerBusClockOut = sclOut_q;
  assign tunerBusClockOeN = sclOeN_q;
  assign tunerBusDataOut = sdaOut_q;
  assign tunerBusDataOeN = sdaOeN_q;

endmodule

//--- testbench/tim_master_monitor.sv
/*
  Port checker of the tuner bus master, bound to each instance.
  Assumes synchronous register strokes and a bench that resolves the bus wires.
*/
`timescale 1ns/1ns
module tim_master_monitor (
  // System side.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic interruptRequestOut,
  // Bus side.
  input wire logic linkClk,
  input wire logic tunerBusClockIn,
  input wire logic tunerBusClockOut,
  input wire logic tunerBusClockOeN,
  input wire logic tunerBusDataIn,
  input wire logic tunerBusDataOut,
  input wire logic tunerBusDataOeN
);
  // Offsets the decoder answers; every other offset reads as zero.
  wire isMapped = (regAddr >= tim_pkg::ADDR_SLAVE && regAddr <= tim_pkg::ADDR_CTRL) ||
    regAddr == tim_pkg::ADDR_IRQ_RAW || regAddr == tim_pkg::ADDR_IRQ_STATUS ||
    regAddr == tim_pkg::ADDR_IRQ_MASK || regAddr == tim_pkg::ADDR_IRQ_CLEAR;
  // Data moves while the clock wire is high only at start and stop.
  sequence startCond;
    tunerBusClockOeN && $fell(tunerBusDataOeN);
  endsequence
  sequence stopCond;
    tunerBusClockOeN && $rose(tunerBusDataOeN);
  endsequence
  mask_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    regWrEn && regAddr == tim_pkg::ADDR_IRQ_MASK && regWrData[1:0] == 2'h0 |-> ##2 !interruptRequestOut)
    else $error("irq stayed high after masking");
  clear_irq_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    regWrEn && regAddr == tim_pkg::ADDR_IRQ_CLEAR && regWrData[1:0] == 2'h3 |-> ##2 !interruptRequestOut)
    else $error("irq stayed high after clear");
  unmapped_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    regRdEn && !isMapped |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  start_reads_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    regRdEn && regAddr == tim_pkg::ADDR_CTRL |=> !regRdData[tim_pkg::CTRL_START_BIT])
    else $error("start bit read back as one");
  irq_status_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    regRdEn && regAddr == tim_pkg::ADDR_IRQ_STATUS |=> (|regRdData[1:0]) == interruptRequestOut)
    else $error("irq pin disagrees with status");
  reset_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(sys_rst) |-> tunerBusClockOeN && tunerBusDataOeN && !interruptRequestOut && regRdData == 8'h00)
    else $error("outputs not idle after reset");
  drive_low_a: assert property (@(posedge linkClk) disable iff (sys_rst)
    !tunerBusClockOut && !tunerBusDataOut)
    else $error("bus output level not low");
  start_hold_a: assert property (@(posedge linkClk) disable iff (sys_rst)
    startCond |-> ##[1:40] !tunerBusClockOeN)
    else $error("clock not pulled after start");
  stop_idle_a: assert property (@(posedge linkClk) disable iff (sys_rst)
    stopCond |-> tunerBusClockOeN [*8])
    else $error("clock pulled right after stop");
endmodule
bind tim_tuner_i2c_master tim_master_monitor mon (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
  .interruptRequestOut(interruptRequestOut), .linkClk(linkClk), .tunerBusClockIn(tunerBusClockIn),
  .tunerBusClockOut(tunerBusClockOut), .tunerBusClockOeN(tunerBusClockOeN),
  .tunerBusDataIn(tunerBusDataIn), .tunerBusDataOut(tunerBusDataOut), .tunerBusDataOeN(tunerBusDataOeN));

//--- testbench/tim_tuner_model.sv
/*
  Behavioural tuner on the two-wire bus: logs bytes it receives, acks them
  unless told to refuse one or an address byte names another device, and returns staged bytes on reads.
  Assumes the bench resolves both open-drain wires.
*/
`timescale 1ns/1ns
module tim_tuner_model #(
  parameter logic [6:0] DEV_ADDR = 7'h3a
) (
  // Resolved wire levels.
  input wire logic scl,
  input wire logic sda,
  // High while the tuner pulls the data wire.
  output logic pullLow
);
  logic [7:0] txData [8];
  logic [7:0] got [$];
  logic [7:0] sh;
  logic rd;
  logic addrNow;
  logic halt;
  int bits = -1;
  int nackAt = -1;
  int di;
  int acks;
  initial pullLow = 0;
  // Start reframes bytes; stop lets go of the wire.
  always @(sda) begin
    if (scl) begin
      bits = -1;
      addrNow = 1;
      di = 0;
      halt = sda;
      pullLow = 0;
    end
  end
  // Bits are taken while the clock is high; a master nack ends a read.
  // The tuner's own address acknowledge is not a master acknowledge, so it is skipped.
  always @(posedge scl) begin
    if (bits >= 0 && bits < 8)
      sh = {sh[6:0], sda};
    else if (bits == 8 && rd && !addrNow && !halt && !pullLow) begin
      if (sda)
        halt = 1;
      else
        acks++;
    end
  end
  // Wire changes only while the clock is low, so no false start or stop.
  always @(negedge scl) begin
    bits = (bits == 8) ? 0 : bits + 1;
    pullLow = 0;
    if (!halt && bits == 8 && (addrNow || !rd)) begin
      got.push_back(sh);
      if (addrNow)
        rd = sh[0];
      pullLow = (got.size() - 1 != nackAt) && (!addrNow || sh[7:1] == DEV_ADDR);
      addrNow = 0;
    end else if (!halt && rd && !addrNow && bits == 8)
      di++;
    else if (!halt && rd && !addrNow && bits >= 0)
      pullLow = !txData[di][7 - bits];
  end
endmodule

//--- testbench/tuner_i2c_master_port_tb.sv
/*
  Self-checking bench of the tuner bus master: register tasks, a tuner model.
  Assumes the design's register map and timing as handed over.
*/
`timescale 1ns/1ns
module tuner_i2c_master_port_tb;
  logic sys_clk = 0, sys_rst = 1, linkClk = 0, regWrEn = 0, regRdEn = 0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, v;
  logic interruptRequestOut, sclOut, sclOeN, sdaOut, sdaOeN, pullLow;
  int errTotal = 0, cmpCount = 0;
  // Open-drain wires with pull-ups.
  wire scl = sclOeN;
  wire sda = sdaOeN && !pullLow;
  always #25 sys_clk = !sys_clk;
  // Link clock, phase unrelated to the system clock.
  initial begin
    #13;
    forever #40 linkClk = !linkClk;
  end
  tim_tuner_i2c_master dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData), .interruptRequestOut(interruptRequestOut),
    .linkClk(linkClk), .tunerBusClockIn(scl), .tunerBusClockOut(sclOut), .tunerBusClockOeN(sclOeN),
    .tunerBusDataIn(sda), .tunerBusDataOut(sdaOut), .tunerBusDataOeN(sdaOeN));
  tim_tuner_model tuner (.scl(scl), .sda(sda), .pullLow(pullLow));
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmpCount++;
    if (g !== e) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Register strokes start one unit after an edge and release a cycle later.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1;
    @(posedge sys_clk);
    #1 regWrEn = 0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rdChk(input string nm, input logic [7:0] a, input logic [7:0] e);
    regAddr = a;
    regRdEn = 1;
    @(posedge sys_clk);
    #1 regRdEn = 0;
    chk(nm, e, regRdData);
    @(posedge sys_clk);
    #1;
  endtask
  // Polls raw status until an outcome shows; a hang ends the run.
  task automatic waitRaw();
    for (int n = 0; n < 20000; n++) begin
      regAddr = tim_pkg::ADDR_IRQ_RAW;
      regRdEn = 1;
      @(posedge sys_clk);
      #1 regRdEn = 0;
      v = regRdData;
      @(posedge sys_clk);
      #1;
      if (v !== 8'h00)
        return;
    end
    errTotal++;
    tallyAndFinish();
  endtask
  task automatic busChk(input logic [7:0] e [$]);
    chk("byte count", 8'(e.size()), 8'(tuner.got.size()));
    foreach (e[i])
      chk("bus byte", e[i], tuner.got[i]);
    tuner.got.delete();
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 sys_rst = 0;
    repeat (10) @(posedge sys_clk);
    #1;
    rdChk("ctrl", tim_pkg::ADDR_CTRL, 8'h00);
    rdChk("slave", tim_pkg::ADDR_SLAVE, 8'h00);
    rdChk("unmapped", 8'h10, 8'h00);
    // Fast write of three bytes with the interrupt enabled.
    wr(tim_pkg::ADDR_IRQ_MASK, 8'h03);
    wr(tim_pkg::ADDR_SLAVE, 8'h74);
    for (int i = 0; i < 8; i++)
      wr(tim_pkg::ADDR_DATA_FIRST + 8'(i), 8'ha0 + 8'(i));
    wr(tim_pkg::ADDR_CTRL, 8'h65);
    rdChk("busy", tim_pkg::ADDR_CTRL, 8'h63);
    wr(tim_pkg::ADDR_DATA_FIRST, 8'hff);
    waitRaw();
    busChk('{8'h74, 8'ha0, 8'ha1, 8'ha2});
    chk("irq", 8'h01, {7'h0, interruptRequestOut});
    rdChk("status", tim_pkg::ADDR_IRQ_STATUS, 8'h01);
    rdChk("held data", tim_pkg::ADDR_DATA_FIRST, 8'ha0);
    wr(tim_pkg::ADDR_IRQ_CLEAR, 8'h03);
    rdChk("cleared", tim_pkg::ADDR_IRQ_RAW, 8'h00);
    // Eight-byte read by polling, with a sub-address phase.
    wr(tim_pkg::ADDR_IRQ_MASK, 8'h00);
    for (int i = 0; i < 8; i++)
      tuner.txData[i] = 8'h90 + 8'(i);
    wr(tim_pkg::ADDR_SLAVE, 8'h75);
    wr(tim_pkg::ADDR_DATA_FIRST, 8'h12);
    wr(tim_pkg::ADDR_CTRL, 8'h0d);
    waitRaw();
    busChk('{8'h74, 8'h12, 8'h75});
    chk("master acks", 8'h07, 8'(tuner.acks));
    rdChk("raw done", tim_pkg::ADDR_IRQ_RAW, 8'h01);
    rdChk("masked", tim_pkg::ADDR_IRQ_STATUS, 8'h00);
    for (int i = 0; i < 8; i++)
      rdChk("read data", tim_pkg::ADDR_DATA_FIRST + 8'(i), 8'h90 + 8'(i));
    // Standard-rate write refused on its second data byte.
    wr(tim_pkg::ADDR_IRQ_CLEAR, 8'h03);
    wr(tim_pkg::ADDR_IRQ_MASK, 8'h03);
    tuner.nackAt = 2;
    wr(tim_pkg::ADDR_SLAVE, 8'h74);
    wr(tim_pkg::ADDR_CTRL, 8'h64);
    waitRaw();
    busChk('{8'h74, 8'h90, 8'h91});
    rdChk("error only", tim_pkg::ADDR_IRQ_RAW, 8'h02);
    chk("irq error", 8'h01, {7'h0, interruptRequestOut});
    wr(tim_pkg::ADDR_IRQ_MASK, 8'h00);
    chk("irq masked", 8'h00, {7'h0, interruptRequestOut});
    tallyAndFinish();
  end
endmodule
